// >>> rtl/slcr_config_top.sv
// Configuration register bank for the synthesizer and modulator
//
// Summary of operation
// - Low three bits route word to register
// - Registers reset to their default words
// - Dither restart value spans seventeen bits
// - Internal source: two-bit charge pump current
// - Source bit set: external resistor scaling
// - Phase offset multiplier field bits 16..12
// - Sign bit sets phase offset polarity
// - Reference scaled by two, one, half, quarter
// - Status pin muxed, lock detect default
// - Separate modulator output and bias enables
// - Select low, external on, driver off: input
// - Otherwise output, driven by pin or driver bit if external off
// - Band from calibration or manual field
// - VCO amplitude zero to sixty-three
// - Charge pump disable bit, enabled at reset
// - All four enables zero powers PLL down
// - External VCO bit, zero amplitude: bypass
`timescale 1ns/1ps
`default_nettype none
module slcr_config_top (
    input  wire logic                                 ref_clk,
    input  wire logic                                 resetn,
    input  wire logic                                 serialClockPin,
    input  wire logic                                 serialDataPin,
    input  wire logic                                 latchEnablePin,
    input  wire logic                                 portDirectionSelectPin,
    input  wire logic [slcr_pkg::STATUS_SRC_N-1:0]    statusSources,
    input  wire logic [slcr_pkg::BAND_W-1:0]          calibratedBand,
    output logic                                      ditherEnable,
    output logic [slcr_pkg::DITH_MAG_W-1:0]           ditherMagnitude,
    output logic [slcr_pkg::DITH_RESTART_W-1:0]       ditherRestart,
    output logic [slcr_pkg::CP_CUR_W-1:0]             chargePumpCurrentSel,
    output logic                                      currentScalingResistor,
    output logic [slcr_pkg::PHASE_W-1:0]              phaseOffsetMult,
    output logic                                      phaseOffsetNegative,
    output logic [slcr_pkg::REF_SCALE_W-1:0]          refScaleSel,
    output logic                                      statusSelectOutput,
    output logic                                      modulatorOutputEnable,
    output logic                                      modulatorBiasEnable,
    output logic                                      portAsInput,
    output logic                                      portDriveEnable,
    output logic                                      outputDivideSelect,
    output logic [slcr_pkg::BAND_W-1:0]               vcoBand,
    output logic [slcr_pkg::AMP_W-1:0]                vcoAmplitude,
    output logic                                      chargePumpEnable,
    output logic                                      pllPowerDown,
    output logic [slcr_pkg::PLL_EN_W-1:0]             pllBlockEnables,
    output logic                                      internalVcoEnable,
    output logic                                      feedbackFromPort
);
    import slcr_pkg::*;

    slcr_word_if wordBus ();

    slcr_word_t ditherReg;
    slcr_word_t cpRefReg;
    slcr_word_t loPathReg;
    slcr_word_t vcoReg;
    slcr_word_t extVcoReg;
    slcr_ctrl_t wordCtrl;
    logic       selStage1Reg;
    logic       selStage2Reg;
    logic       selStage3Reg;
    logic       selFiltReg;
    logic       extInSel;
    logic       driverSel;
    logic       bypassVco;

    slcr_serial_rx u_rx (
        .ref_clk        (ref_clk),
        .resetn         (resetn),
        .serialClockPin (serialClockPin),
        .serialDataPin  (serialDataPin),
        .latchEnablePin (latchEnablePin),
        .wordOut        (wordBus.src)
    );

    assign wordCtrl = wordBus.word[CTRL_W-1:0];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ditherReg <= RST_DITHER;
            cpRefReg  <= RST_CPREF;
            loPathReg <= RST_LOPATH;
            vcoReg    <= RST_VCO;
            extVcoReg <= RST_EXTVCO;
        end else if (wordBus.wordValid) begin
            // Codes zero to two belong to the divider bank, not here
            case (wordCtrl)
                ADDR_DITHER: ditherReg <= wordBus.word;
                ADDR_CPREF:  cpRefReg  <= wordBus.word;
                ADDR_LOPATH: loPathReg <= wordBus.word;
                ADDR_VCO:    vcoReg    <= wordBus.word;
                ADDR_EXTVCO: extVcoReg <= wordBus.word;
                default: begin
                end
            endcase
        end
    end

    // Port select pin is asynchronous; filtered like the serial pins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            selStage1Reg <= 1'b0;
            selStage2Reg <= 1'b0;
            selStage3Reg <= 1'b0;
            selFiltReg   <= 1'b0;
        end else begin
            selStage1Reg <= portDirectionSelectPin;
            selStage2Reg <= selStage1Reg;
            selStage3Reg <= selStage2Reg;
            if (selStage2Reg == selStage3Reg) begin
                selFiltReg <= selStage3Reg;
            end
        end
    end

    // host tunes dither; fields passed through unchanged
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ditherEnable    <= RST_DITHER[DITH_EN_BIT];
            ditherMagnitude <= RST_DITHER[DITH_MAG_LSB +: DITH_MAG_W];
            ditherRestart   <= RST_DITHER[DITH_RESTART_LSB +: DITH_RESTART_W];
        end else begin
            ditherEnable    <= ditherReg[DITH_EN_BIT];
            ditherMagnitude <= ditherReg[DITH_MAG_LSB +: DITH_MAG_W];
            ditherRestart   <= ditherReg[DITH_RESTART_LSB +: DITH_RESTART_W];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chargePumpCurrentSel   <= RST_CPREF[CP_CUR_LSB +: CP_CUR_W];
            currentScalingResistor <= RST_CPREF[CP_SRC_BIT];
            phaseOffsetMult        <= RST_CPREF[PHASE_LSB +: PHASE_W];
            phaseOffsetNegative    <= RST_CPREF[PHASE_SIGN_BIT];
            refScaleSel            <= RST_CPREF[REF_SCALE_LSB +: REF_SCALE_W];
        end else begin
            chargePumpCurrentSel   <= cpRefReg[CP_CUR_LSB +: CP_CUR_W];
            currentScalingResistor <= cpRefReg[CP_SRC_BIT];
            phaseOffsetMult        <= cpRefReg[PHASE_LSB +: PHASE_W];
            phaseOffsetNegative    <= cpRefReg[PHASE_SIGN_BIT];
            refScaleSel            <= cpRefReg[REF_SCALE_LSB +: REF_SCALE_W];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            statusSelectOutput <= 1'b0;
        end else begin
            statusSelectOutput <= statusSources[cpRefReg[MUX_LSB +: MUX_W]];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            modulatorOutputEnable <= RST_LOPATH[MOD_OUT_BIT];
            modulatorBiasEnable   <= RST_LOPATH[MOD_BIAS_BIT];
        end else begin
            modulatorOutputEnable <= loPathReg[MOD_OUT_BIT];
            modulatorBiasEnable   <= loPathReg[MOD_BIAS_BIT];
        end
    end

    assign extInSel  = loPathReg[LO_EXT_BIT];
    assign driverSel = loPathReg[LO_DRV_BIT];

    // Pin high with external input set is not a listed mode; the
    // port is then neither input nor driven, since the external bit holds the driver off
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            portAsInput        <= 1'b0;
            portDriveEnable    <= 1'b0;
            outputDivideSelect <= RST_LOPATH[LO_DIV_BIT];
        end else begin
            portAsInput        <= !selFiltReg && extInSel && !driverSel;
            // drive when pin or driver bit, external bit clear
            portDriveEnable    <= !extInSel && (selFiltReg || driverSel);
            outputDivideSelect <= loPathReg[LO_DIV_BIT];
        end
    end

    assign bypassVco = extVcoReg[EXT_VCO_BIT] &&
                       (vcoReg[AMP_LSB +: AMP_W] == '0);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            vcoBand           <= RST_VCO[BAND_LSB +: BAND_W];
            vcoAmplitude      <= RST_VCO[AMP_LSB +: AMP_W];
            chargePumpEnable  <= 1'b1;
            pllPowerDown      <= 1'b0;
            pllBlockEnables   <= RST_VCO[PLL_EN_LSB +: PLL_EN_W];
            internalVcoEnable <= 1'b1;
            feedbackFromPort  <= 1'b0;
        end else begin
            vcoBand <= vcoReg[BAND_SRC_BIT] ? vcoReg[BAND_LSB +: BAND_W]
                                            : calibratedBand;
            vcoAmplitude      <= vcoReg[AMP_LSB +: AMP_W];
            chargePumpEnable  <= !vcoReg[CP_DIS_BIT];
            pllPowerDown      <= (vcoReg[PLL_EN_LSB +: PLL_EN_W] == '0);
            pllBlockEnables   <= vcoReg[PLL_EN_LSB +: PLL_EN_W];
            internalVcoEnable <= !bypassVco;
            feedbackFromPort  <= bypassVco;
        end
    end

    sequence s_writeSel(slcr_ctrl_t code);
        wordBus.wordValid && wordCtrl == code;
    endsequence

    property p_routeDither;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_DITHER) |=> ditherReg == $past(wordBus.word);
    endproperty
    a_routeDither: assert property (p_routeDither)
        else $error("dither word not stored");

    property p_routeVco;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_VCO) |=> vcoReg == $past(wordBus.word)
            && $stable(cpRefReg) && $stable(loPathReg);
    endproperty
    a_routeVco: assert property (p_routeVco)
        else $error("VCO word misrouted");

    property p_resetDefaults;
        @(posedge ref_clk)
        $rose(resetn) |-> ditherReg == RST_DITHER && cpRefReg == RST_CPREF
            && loPathReg == RST_LOPATH && vcoReg == RST_VCO;
    endproperty
    a_resetDefaults: assert property (p_resetDefaults)
        else $error("register default missing after reset");

    property p_noSpontaneous;
        @(posedge ref_clk) disable iff (!resetn)
        ($changed(cpRefReg) || $changed(extVcoReg)) |-> $past(wordBus.wordValid);
    endproperty
    a_noSpontaneous: assert property (p_noSpontaneous)
        else $error("register changed without a latched word");

    property p_portMode;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_LOPATH) ##1 $stable(selFiltReg) |=>
            portAsInput == (!$past(selFiltReg) && $past(extInSel)
                && !$past(driverSel));
    endproperty
    a_portMode: assert property (p_portMode)
        else $error("port input mode wrong after write");

    property p_portDrive;
        @(posedge ref_clk) disable iff (!resetn)
        ##1 (portDriveEnable == (!$past(extInSel)
            && ($past(selFiltReg) || $past(driverSel))));
    endproperty
    a_portDrive: assert property (p_portDrive)
        else $error("port drive enable wrong");

    property p_pllDown;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_VCO) ##0
            (wordBus.word[PLL_EN_LSB +: PLL_EN_W] == '0)
            |-> ##2 pllPowerDown;
    endproperty
    a_pllDown: assert property (p_pllDown)
        else $error("PLL not powered down");

    property p_bypass;
        @(posedge ref_clk) disable iff (!resetn)
        bypassVco |=> feedbackFromPort && !internalVcoEnable;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("external oscillator bypass missing");

    property p_bandSource;
        @(posedge ref_clk) disable iff (!resetn)
        !vcoReg[BAND_SRC_BIT] |=> vcoBand == $past(calibratedBand);
    endproperty
    a_bandSource: assert property (p_bandSource)
        else $error("band not taken from calibration");

    property p_statusMux;
        @(posedge ref_clk) disable iff (!resetn)
        cpRefReg[MUX_LSB +: MUX_W] == '0 |=>
            statusSelectOutput == $past(statusSources[0]);
    endproperty
    a_statusMux: assert property (p_statusMux)
        else $error("status pin not showing lock detect");

    property p_chargePump;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_VCO) |-> ##2
            chargePumpEnable == !$past(wordBus.word[CP_DIS_BIT], 2);
    endproperty
    a_chargePump: assert property (p_chargePump)
        else $error("charge pump enable does not follow write");

    property p_cpCurrent;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_CPREF) |-> ##2
            chargePumpCurrentSel ==
                $past(wordBus.word[CP_CUR_LSB +: CP_CUR_W], 2)
            && currentScalingResistor == $past(wordBus.word[CP_SRC_BIT], 2);
    endproperty
    a_cpCurrent: assert property (p_cpCurrent)
        else $error("charge pump current code not applied");

    property p_phaseOffset;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_CPREF) |-> ##2
            phaseOffsetMult == $past(wordBus.word[PHASE_LSB +: PHASE_W], 2)
            && phaseOffsetNegative ==
                $past(wordBus.word[PHASE_SIGN_BIT], 2)
            && refScaleSel ==
                $past(wordBus.word[REF_SCALE_LSB +: REF_SCALE_W], 2);
    endproperty
    a_phaseOffset: assert property (p_phaseOffset)
        else $error("phase offset or reference scale not applied");

    property p_modulator;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_LOPATH) |-> ##2
            modulatorOutputEnable == $past(wordBus.word[MOD_OUT_BIT], 2)
            && modulatorBiasEnable == $past(wordBus.word[MOD_BIAS_BIT], 2);
    endproperty
    a_modulator: assert property (p_modulator)
        else $error("modulator enables not applied");

    property p_amplitude;
        @(posedge ref_clk) disable iff (!resetn)
        s_writeSel(ADDR_VCO) |-> ##2
            vcoAmplitude == $past(wordBus.word[AMP_LSB +: AMP_W], 2);
    endproperty
    a_amplitude: assert property (p_amplitude)
        else $error("oscillator amplitude not applied");
endmodule
`default_nettype wire

// >>> rtl/slcr_pkg.sv
// Constants and types shared by the synthesizer configuration bank
package slcr_pkg;
    localparam int WORD_W       = 24;
    localparam int CTRL_W       = 3;
    localparam int SYNC_STAGES  = 3;
    localparam int BIT_CNT_W    = 5;
    localparam int STATUS_SRC_N = 8;

    typedef logic [WORD_W-1:0] slcr_word_t;
    typedef logic [CTRL_W-1:0] slcr_ctrl_t;

    // Register select codes in the low bits of each word
    localparam slcr_ctrl_t ADDR_DITHER = 3'h3;
    localparam slcr_ctrl_t ADDR_CPREF  = 3'h4;
    localparam slcr_ctrl_t ADDR_LOPATH = 3'h5;
    localparam slcr_ctrl_t ADDR_VCO    = 3'h6;
    localparam slcr_ctrl_t ADDR_EXTVCO = 3'h7;

    localparam slcr_word_t RST_DITHER = 24'h10000b;
    localparam slcr_word_t RST_CPREF  = 24'h0aa7e4;
    localparam slcr_word_t RST_LOPATH = 24'h0000d5;
    localparam slcr_word_t RST_VCO    = 24'h1e2106;
    localparam slcr_word_t RST_EXTVCO = 24'h000007;

    // Idle pin levels {latch, data, clock}, so reset makes no false edge
    localparam logic [2:0] SERIAL_PIN_IDLE = 3'h4;

    localparam logic [BIT_CNT_W-1:0] FULL_WORD_BITS = 5'h18;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX    = 5'h1f;

    // Dither control fields
    localparam int DITH_RESTART_LSB = 3;
    localparam int DITH_RESTART_W   = 17;
    localparam int DITH_EN_BIT      = 20;
    localparam int DITH_MAG_LSB     = 21;
    localparam int DITH_MAG_W       = 3;

    // Charge pump and reference fields
    localparam int CP_CUR_LSB     = 10;
    localparam int CP_CUR_W       = 2;
    localparam int PHASE_LSB      = 12;
    localparam int PHASE_W        = 5;
    localparam int PHASE_SIGN_BIT = 17;
    localparam int CP_SRC_BIT     = 18;
    localparam int REF_SCALE_LSB  = 19;
    localparam int REF_SCALE_W    = 2;
    localparam int MUX_LSB        = 21;
    localparam int MUX_W          = 3;

    // LO path and modulator fields
    localparam int LO_DRV_BIT   = 3;
    localparam int LO_EXT_BIT   = 4;
    localparam int LO_DIV_BIT   = 5;
    localparam int MOD_BIAS_BIT = 6;
    localparam int MOD_OUT_BIT  = 7;

    // VCO control fields
    localparam int BAND_LSB     = 3;
    localparam int BAND_W       = 6;
    localparam int BAND_SRC_BIT = 9;
    localparam int AMP_LSB      = 10;
    localparam int AMP_W        = 6;
    localparam int CP_DIS_BIT   = 16;
    localparam int PLL_EN_LSB   = 17;
    localparam int PLL_EN_W     = 4;

    // External VCO field
    localparam int EXT_VCO_BIT = 22;
endpackage

// >>> rtl/slcr_word_if.sv
// Carrier of latched configuration words between receiver and bank
`timescale 1ns/1ps
`default_nettype none
interface slcr_word_if;
    import slcr_pkg::*;
    slcr_word_t word;
    logic       wordValid;
    modport src (output word, output wordValid);
    modport snk (input word, input wordValid);
endinterface
`default_nettype wire

// >>> rtl/slcr_serial_rx.sv
// Three-wire serial receiver that assembles latched 24-bit words
`timescale 1ns/1ps
`default_nettype none
module slcr_serial_rx (
    input  wire logic  ref_clk,
    input  wire logic  resetn,
    input  wire logic  serialClockPin,
    input  wire logic  serialDataPin,
    input  wire logic  latchEnablePin,
    slcr_word_if.src   wordOut
);
    import slcr_pkg::*;

    logic [2:0]             pinRaw;
    logic [2:0]             stage1Reg;
    logic [2:0]             stage2Reg;
    logic [2:0]             stage3Reg;
    logic [2:0]             filtReg;
    logic [2:0]             prevReg;
    slcr_word_t             shiftReg;
    logic [BIT_CNT_W-1:0]   bitCountReg;
    logic                   clkRise;
    logic                   latchRise;

    assign pinRaw = {latchEnablePin, serialDataPin, serialClockPin};

    // Glitch filter: a pin level counts once stages two and three agree
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                stage1Reg[i] <= SERIAL_PIN_IDLE[i];
                stage2Reg[i] <= SERIAL_PIN_IDLE[i];
                stage3Reg[i] <= SERIAL_PIN_IDLE[i];
                filtReg[i]   <= SERIAL_PIN_IDLE[i];
                prevReg[i]   <= SERIAL_PIN_IDLE[i];
            end else begin
                stage1Reg[i] <= pinRaw[i];
                stage2Reg[i] <= stage1Reg[i];
                stage3Reg[i] <= stage2Reg[i];
                if (stage2Reg[i] == stage3Reg[i]) begin
                    filtReg[i] <= stage3Reg[i];
                end
                prevReg[i] <= filtReg[i];
            end
        end
    end

    assign clkRise   = filtReg[0] & ~prevReg[0];
    assign latchRise = filtReg[2] & ~prevReg[2];

    // Shifting happens only while the latch line is low, MSB first
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shiftReg    <= '0;
            bitCountReg <= '0;
        end else if (latchRise) begin
            bitCountReg <= '0;
        end else if (clkRise && !filtReg[2]) begin
            shiftReg <= {shiftReg[WORD_W-2:0], filtReg[1]};
            if (bitCountReg != BIT_CNT_MAX) begin
                bitCountReg <= bitCountReg + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wordOut.word      <= '0;
            wordOut.wordValid <= 1'b0;
        end else begin
            wordOut.wordValid <= latchRise && (bitCountReg == FULL_WORD_BITS);
            if (latchRise && (bitCountReg == FULL_WORD_BITS)) begin
                wordOut.word <= shiftReg;
            end
        end
    end

    property p_wholeWord;
        @(posedge ref_clk) disable iff (!resetn)
        wordOut.wordValid |-> $past(bitCountReg) == FULL_WORD_BITS;
    endproperty
    a_wholeWord: assert property (p_wholeWord)
        else $error("word latched from a partial shift");
endmodule
`default_nettype wire

// >>> verif/slcr_host_model.sv
// Serial host model that shifts configuration words into the bank
`timescale 1ns/1ps
`default_nettype none
module slcr_host_model (
    input  wire logic ref_clk,
    output logic      serialClock,
    output logic      serialData,
    output logic      latchEnable
);
    import slcr_pkg::*;

    int gap = 3;

    initial begin
        serialClock = 1'b0;
        serialData  = 1'b0;
        latchEnable = 1'b1;
    end

    // Three cycles at least, so the pin filters never drop a level
    task automatic hold();
        repeat (gap) @(negedge ref_clk);
    endtask

    // Low n bits, MSB first; n below 24 makes a runt word
    task automatic send(input slcr_word_t w, input int n);
        latchEnable = 1'b0;
        hold();
        for (int i = n - 1; i >= 0; i--) begin
            serialData = w[i];
            hold();
            serialClock = 1'b1;
            hold();
            serialClock = 1'b0;
            hold();
        end
        latchEnable = 1'b1;
        // Released line shows the inverse, never a stale bit
        serialData = ~serialData;
        hold();
    endtask
endmodule
`default_nettype wire

// >>> verif/test_synth_lo_config_regs.sv
// Self-checking bench for the synthesizer configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_synth_lo_config_regs;
    import slcr_pkg::*;
    logic                    ref_clk    = 1'b0;
    logic                    resetn     = 1'b0;
    logic                    sel        = 1'b0;
    logic [STATUS_SRC_N-1:0] src        = 8'h00;
    logic [BAND_W-1:0]       cal        = 6'h00;
    wire logic               sck;
    wire logic               sdi;
    wire logic               le;
    wire logic [57:0]        obs;
    logic [57:0]             expQ[$];
    slcr_word_t              d, c, l, v, e;
    int                      seed       = 67;
    int                      n_mismatch = 0;
    int                      n_compared = 0;
    event                    chk;

    always #4 ref_clk = ~ref_clk;

    slcr_host_model host (.ref_clk(ref_clk), .serialClock(sck),
                          .serialData(sdi), .latchEnable(le));

    slcr_config_top dut (
        .ref_clk               (ref_clk),
        .resetn                (resetn),
        .serialClockPin        (sck),
        .serialDataPin         (sdi),
        .latchEnablePin        (le),
        .portDirectionSelectPin(sel),
        .statusSources         (src),
        .calibratedBand        (cal),
        .ditherEnable          (obs[57]),
        .ditherMagnitude       (obs[56:54]),
        .ditherRestart         (obs[53:37]),
        .chargePumpCurrentSel  (obs[36:35]),
        .currentScalingResistor(obs[34]),
        .phaseOffsetMult       (obs[33:29]),
        .phaseOffsetNegative   (obs[28]),
        .refScaleSel           (obs[27:26]),
        .statusSelectOutput    (obs[25]),
        .modulatorOutputEnable (obs[24]),
        .modulatorBiasEnable   (obs[23]),
        .portAsInput           (obs[22]),
        .portDriveEnable       (obs[21]),
        .outputDivideSelect    (obs[20]),
        .vcoBand               (obs[19:14]),
        .vcoAmplitude          (obs[13:8]),
        .chargePumpEnable      (obs[7]),
        .pllPowerDown          (obs[6]),
        .pllBlockEnables       (obs[5:2]),
        .internalVcoEnable     (obs[1]),
        .feedbackFromPort      (obs[0])
    );

    function automatic logic [57:0] model();
        logic bp;
        bp = e[22] && (v[15:10] == 6'h00);
        return {d[20], d[23:21], d[19:3], c[11:10], c[18], c[16:12],
                c[17], c[20:19], src[c[23:21]], l[7], l[6],
                !sel && l[4] && !l[3], !l[4] && (sel || l[3]), l[5],
                v[9] ? v[8:3] : cal, v[15:10], !v[16],
                v[20:17] == 4'h0, v[20:17], !bp, bp};
    endfunction

    task automatic expect_now();
        expQ.push_back(model());
        ->chk;
    endtask

    always @(chk) begin
        logic [57:0] want;
        want = expQ.pop_front();
        n_compared++;
        if (obs !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, obs, want);
        end
    end

    // Only whole words may land; runts and low codes leave the model as is
    task automatic wr(input slcr_word_t w, input int n);
        src = 8'($random(seed));
        cal = 6'($random(seed));
        host.send(w, n);
        if (n == 24) begin
            case (w[2:0])
                3'h3: d = w;
                3'h4: c = w;
                3'h5: l = w;
                3'h6: v = w;
                3'h7: e = w;
                default: ;
            endcase
        end
        repeat (10) @(negedge ref_clk);
        expect_now();
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        d = 24'h10000b;
        c = 24'h0aa7e4;
        l = 24'h0000d5;
        v = 24'h1e2106;
        e = RST_EXTVCO;
        repeat (12) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (8) @(negedge ref_clk);
        expect_now();
        wr(24'h30000b, 24);
        for (int i = 0; i < 20; i++) begin
            wr({21'($random(seed)), 3'(3 + i % 5)}, 24);
        end
        wr(24'h400007, 24);
        wr(24'h000206, 24);
        wr(24'h01fffe, 24);
        for (int k = 0; k < 3; k++) begin
            wr({21'($random(seed)), 3'(k)}, 24);
        end
        wr(24'hfffffc, 23);
        host.gap = 5;
        for (int m = 0; m < 8; m++) begin
            wr({18'h0, 3'(m), 3'h5}, 24);
            sel = 1'b1;
            repeat (8) @(negedge ref_clk);
            expect_now();
            sel = 1'b0;
        end
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
